// [design/rpx_pkg.sv]
package rpx_pkg;

    // Array geometry, pointer and pixel widths.
    localparam int unsigned ACTIVE_ROWS = 3024;
    localparam int unsigned ACTIVE_COLS = 4536;
    localparam int unsigned EXTRA_LINES = 24;
    localparam int unsigned TOTAL_ROWS  = ACTIVE_ROWS + EXTRA_LINES;
    localparam int unsigned TOTAL_COLS  = ACTIVE_COLS + EXTRA_LINES;
    localparam int unsigned COL_GROUP   = 4;
    localparam int unsigned PTR_W       = 13;
    localparam int unsigned PIX_W       = 10;
    localparam int unsigned NUM_OUT     = 4;

    // Configuration word layout, shifted in over the serial port or written over the bus.
    localparam int unsigned CFG_W        = 12;
    localparam int unsigned CFG_XSUB_LSB = 0;
    localparam int unsigned CFG_YSUB_LSB = 3;
    localparam int unsigned CFG_AMP_LSB  = 6;
    localparam int unsigned CFG_XB_AUTO  = 10;
    localparam int unsigned CFG_XB_INIT  = 11;
    localparam logic [CFG_W-1:0] CFG_RESET = 12'h7C1;

    // Subsampling codes for the two pointer kinds.
    localparam logic [2:0] XSUB_SKIP20 = 3'h3;
    localparam logic [2:0] XSUB_SKIP4  = 3'h4;
    localparam logic [2:0] XSUB_SKIP8  = 3'h5;
    localparam logic [2:0] YSUB_FULL   = 3'h1;
    localparam logic [2:0] YSUB_SKIP4  = 3'h3;
    localparam logic [2:0] YSUB_SKIP10 = 3'h5;
    localparam logic [PTR_W-1:0] SKIP_2  = 13'h0002;
    localparam logic [PTR_W-1:0] SKIP_4  = 13'h0004;
    localparam logic [PTR_W-1:0] SKIP_8  = 13'h0008;
    localparam logic [PTR_W-1:0] SKIP_10 = 13'h000A;
    localparam logic [PTR_W-1:0] SKIP_20 = 13'h0014;

    // Register map on the bus.
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CONFIG    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h04;
    localparam logic [ADDR_W-1:0] REG_READ_ROW  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_RESET_ROW = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_COLUMN    = 8'h10;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_SIG,
        SEQ_RST,
        SEQ_REF,
        SEQ_OUT
    } rpx_seq_t;

endpackage

// [design/rpx_pointer.sv]
`timescale 1ns/10ps
`default_nettype none
module rpx_pointer #(
    parameter int unsigned TOTAL  = 3048,
    parameter int unsigned ACTIVE = 3024,
    parameter int unsigned GROUP  = 1,
    parameter bit          PAIRED = 1'b1
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     step_clk,
    input  wire logic                     sync,
    input  wire logic [rpx_pkg::PTR_W-1:0] skip,
    output logic      [rpx_pkg::PTR_W-1:0] pos,
    output logic                          adv
);
    import rpx_pkg::*;

    localparam logic [PTR_W-1:0] TOTAL_C  = PTR_W'(TOTAL);
    localparam logic [PTR_W-1:0] ACTIVE_C = PTR_W'(ACTIVE);
    localparam logic [PTR_W-1:0] GROUP_C  = PTR_W'(GROUP);

    typedef struct packed {
        logic             clk_d;
        logic [PTR_W-1:0] pos;
        logic             adv;
    } rpx_ptr_st_t;

    rpx_ptr_st_t st_ff;
    rpx_ptr_st_t nxt_st;
    logic        rise;
    logic [PTR_W:0] step;

    assign rise = step_clk & ~st_ff.clk_d;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.clk_d = step_clk;
        nxt_st.adv   = 1'b0;
        step         = {1'b0, st_ff.pos} + {1'b0, GROUP_C};
        // The extra lines past the active area never subsample.
        if ((st_ff.pos < ACTIVE_C) && (!PAIRED || st_ff.pos[0])) begin
            step = step + {1'b0, skip};
            if (step > {1'b0, ACTIVE_C}) begin
                step = {1'b0, ACTIVE_C};
            end
        end
        if (rise) begin
            nxt_st.adv = 1'b1;
            if (sync) begin
                nxt_st.pos = '0;
            end else if (step >= {1'b0, TOTAL_C}) begin
                nxt_st.pos = '0;
            end else begin
                nxt_st.pos = step[PTR_W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pos = st_ff.pos;
    assign adv = st_ff.adv;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ptr_sync_a: assert property (rise && sync |=> pos == '0)
        else $error("Pointer did not return to the first line on sync.");
    ptr_step_a: assert property (
        rise && !sync && skip == '0 && (st_ff.pos + GROUP_C) < TOTAL_C
        |=> pos == $past(st_ff.pos) + GROUP_C && adv)
        else $error("Pointer did not advance by one step.");
    ptr_still_a: assert property (!rise |=> $stable(pos) && !adv)
        else $error("Pointer moved without a clock edge.");

endmodule // rpx_pointer
`default_nettype wire

// [design/rpx_top.sv]
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module rpx_top (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [rpx_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [rpx_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       cfg_sclk,
    input  wire logic                       cfg_sdata,
    input  wire logic                       cfg_load,
    input  wire logic                       readout_pointer_clock,
    input  wire logic                       readout_pointer_sync,
    input  wire logic                       reset_pointer_clock,
    input  wire logic                       reset_pointer_sync,
    input  wire logic                       column_clock,
    input  wire logic                       column_sync,
    input  wire logic                       crossbar_clock,
    input  wire logic                       crossbar_sync,
    input  wire logic [rpx_pkg::PIX_W-1:0]  pixel_level0,
    input  wire logic [rpx_pkg::PIX_W-1:0]  pixel_level1,
    input  wire logic [rpx_pkg::PIX_W-1:0]  pixel_level2,
    input  wire logic [rpx_pkg::PIX_W-1:0]  pixel_level3,
    output logic      [rpx_pkg::PTR_W-1:0]  read_row,
    output logic      [rpx_pkg::PTR_W-1:0]  reset_row,
    output logic      [rpx_pkg::PTR_W-1:0]  column,
    output logic                            shutter_reset_pulse,
    output logic                            signal_sample_hold,
    output logic                            row_reset_pulse,
    output logic      [rpx_pkg::PTR_W-1:0]  row_reset_addr,
    output logic                            reset_level_sample_hold,
    output logic                            crossbar_swapped,
    output logic      [3:0]                 amp_operate,
    output logic      [rpx_pkg::PIX_W-1:0]  pixel_out0,
    output logic      [rpx_pkg::PIX_W-1:0]  pixel_out1,
    output logic      [rpx_pkg::PIX_W-1:0]  pixel_out2,
    output logic      [rpx_pkg::PIX_W-1:0]  pixel_out3
);
    import rpx_pkg::*;

    typedef struct packed {
        logic                             aw_have;
        logic [ADDR_W-1:0]                awaddr;
        logic                             w_have;
        logic [31:0]                      wdata;
        logic [3:0]                       wstrb;
        logic                             awready;
        logic                             wready;
        logic                             bvalid;
        logic [1:0]                       bresp;
        logic                             arready;
        logic                             rvalid;
        logic [31:0]                      rdata;
        logic [1:0]                       rresp;
        logic [CFG_W-1:0]                 cfg;
        logic [CFG_W-1:0]                 shift;
        logic                             sclk_d;
        logic                             load_d;
        logic                             xclk_d;
        logic                             xbar;
        rpx_seq_t                         seq;
        logic [NUM_OUT-1:0][PIX_W-1:0]    sig;
        logic [NUM_OUT-1:0][PIX_W-1:0]    lvl;
        logic [NUM_OUT-1:0][PIX_W-1:0]    diff;
        logic [NUM_OUT-1:0][PIX_W-1:0]    out;
        logic                             ssh;
        logic                             rsh;
        logic                             row_rst;
        logic [PTR_W-1:0]                 rst_addr;
    } rpx_st_t;

    rpx_st_t                       st_ff;
    rpx_st_t                       nxt_st;
    logic [NUM_OUT-1:0][PIX_W-1:0] pix_in;
    logic [NUM_OUT-1:0][PIX_W-1:0] routed;
    logic [PTR_W-1:0]              yskip;
    logic [PTR_W-1:0]              xskip;
    logic                          rd_adv;
    logic                          rs_adv;
    logic                          load_rise;
    logic                          cfg_wr;
    logic                          xclk_rise;

    assign pix_in    = {pixel_level3, pixel_level2, pixel_level1, pixel_level0};
    assign load_rise = cfg_load & ~st_ff.load_d;
    assign xclk_rise = crossbar_clock & ~st_ff.xclk_d;
    assign cfg_wr    = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid
                       && st_ff.awaddr == REG_CONFIG;

    ////////////////////////////////////////////////////////////////////////////////
    // Skip distances decoded from the active configuration word.
    always_comb begin
        unique case (st_ff.cfg[CFG_YSUB_LSB +: 3])
            YSUB_FULL:   yskip = '0;
            YSUB_SKIP4:  yskip = SKIP_4;
            YSUB_SKIP10: yskip = SKIP_10;
            default:     yskip = SKIP_2;
        endcase
        unique case (st_ff.cfg[CFG_XSUB_LSB +: 3])
            XSUB_SKIP20: xskip = SKIP_20;
            XSUB_SKIP4:  xskip = SKIP_4;
            XSUB_SKIP8:  xskip = SKIP_8;
            default:     xskip = '0;
        endcase
    end

    rpx_pointer #(.TOTAL(TOTAL_ROWS), .ACTIVE(ACTIVE_ROWS), .GROUP(1), .PAIRED(1'b1))
    u_read_ptr (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .step_clk (readout_pointer_clock),
        .sync     (readout_pointer_sync),
        .skip     (yskip),
        .pos      (read_row),
        .adv      (rd_adv)
    );

    // The shutter pointer shares the subsampling of the readout pointer so that a lead
    // set by the controller is preserved row for row.
    rpx_pointer #(.TOTAL(TOTAL_ROWS), .ACTIVE(ACTIVE_ROWS), .GROUP(1), .PAIRED(1'b1))
    u_reset_ptr (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .step_clk (reset_pointer_clock),
        .sync     (reset_pointer_sync),
        .skip     (yskip),
        .pos      (reset_row),
        .adv      (rs_adv)
    );

    rpx_pointer #(.TOTAL(TOTAL_COLS), .ACTIVE(ACTIVE_COLS), .GROUP(COL_GROUP), .PAIRED(1'b0))
    u_col_ptr (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .step_clk (column_clock),
        .sync     (column_sync),
        .skip     (xskip),
        .pos      (column),
        .adv      ()
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Green sits on even columns of green-red rows and odd columns of the others, so
    // swapping neighbour pairs on alternate rows keeps green on outputs 0 and 2.
    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            routed[i] = st_ff.xbar ? st_ff.diff[i ^ 1] : st_ff.diff[i];
        end
    end

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.sclk_d = cfg_sclk;
        nxt_st.load_d = cfg_load;
        nxt_st.xclk_d = crossbar_clock;
        nxt_st.ssh    = 1'b0;
        nxt_st.rsh    = 1'b0;
        nxt_st.row_rst = 1'b0;

        // Serial configuration port: bits shift in quietly and only the load edge
        // commits them, so a half-shifted word never reaches the logic.
        if (cfg_sclk && !st_ff.sclk_d) begin
            nxt_st.shift = {st_ff.shift[CFG_W-2:0], cfg_sdata};
        end

        // Bus write channels are taken in either order and answered once both are held.
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_have = 1'b1;
            nxt_st.wdata  = s_axi_wdata;
            nxt_st.wstrb  = s_axi_wstrb;
        end
        if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid) begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = (st_ff.awaddr == REG_CONFIG) ? RESP_OKAY : RESP_SLVERR;
            if (cfg_wr) begin
                if (st_ff.wstrb[0]) begin
                    nxt_st.cfg[7:0] = st_ff.wdata[7:0];
                end
                if (st_ff.wstrb[1]) begin
                    nxt_st.cfg[CFG_W-1:8] = st_ff.wdata[CFG_W-1:8];
                end
            end
        end else if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // A serial load in the same cycle as a bus write overrides it.
        if (load_rise) begin
            nxt_st.cfg = st_ff.shift;
        end

        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CONFIG:    nxt_st.rdata = {20'h00000, st_ff.cfg};
                REG_STATUS:    nxt_st.rdata = {28'h0000000, st_ff.seq != SEQ_IDLE,
                                               st_ff.cfg[CFG_XB_AUTO], 1'b0, st_ff.xbar};
                REG_READ_ROW:  nxt_st.rdata = {19'h00000, read_row};
                REG_RESET_ROW: nxt_st.rdata = {19'h00000, reset_row};
                REG_COLUMN:    nxt_st.rdata = {19'h00000, column};
                default: begin
                    nxt_st.rdata = 32'h00000000;
                    nxt_st.rresp = RESP_SLVERR;
                end
            endcase
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
        nxt_st.wready  = !nxt_st.w_have && !nxt_st.bvalid;
        nxt_st.arready = !nxt_st.rvalid;

        // Crossbar: sync takes priority over toggling on the same clock edge.
        if (xclk_rise) begin
            if (crossbar_sync) begin
                nxt_st.xbar = st_ff.cfg[CFG_XB_INIT];
            end else if (st_ff.cfg[CFG_XB_AUTO]) begin
                nxt_st.xbar = ~st_ff.xbar;
            end
        end

        // Per-row double sampling: signal, second reset of the same row, reset level.
        unique case (st_ff.seq)
            SEQ_IDLE: begin
                if (rd_adv) begin
                    nxt_st.seq = SEQ_SIG;
                end
            end
            SEQ_SIG: begin
                nxt_st.ssh      = 1'b1;
                nxt_st.sig      = pix_in;
                nxt_st.rst_addr = read_row;
                nxt_st.seq      = SEQ_RST;
            end
            SEQ_RST: begin
                nxt_st.row_rst = 1'b1;
                nxt_st.seq     = SEQ_REF;
            end
            SEQ_REF: begin
                nxt_st.rsh = 1'b1;
                nxt_st.lvl = pix_in;
                nxt_st.seq = SEQ_OUT;
            end
            SEQ_OUT: begin
                // Video falls with light, so reset level minus signal, floored at zero.
                for (int i = 0; i < NUM_OUT; i++) begin
                    nxt_st.diff[i] = (st_ff.lvl[i] > st_ff.sig[i])
                                     ? PIX_W'(st_ff.lvl[i] - st_ff.sig[i]) : '0;
                end
                nxt_st.seq = SEQ_IDLE;
            end
        endcase

        for (int i = 0; i < NUM_OUT; i++) begin
            nxt_st.out[i] = st_ff.cfg[CFG_AMP_LSB + i] ? routed[i] : '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff     <= '0;
            st_ff.cfg <= CFG_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign s_axi_awready           = st_ff.awready;
    assign s_axi_wready            = st_ff.wready;
    assign s_axi_bvalid            = st_ff.bvalid;
    assign s_axi_bresp             = st_ff.bresp;
    assign s_axi_arready           = st_ff.arready;
    assign s_axi_rvalid            = st_ff.rvalid;
    assign s_axi_rdata             = st_ff.rdata;
    assign s_axi_rresp             = st_ff.rresp;
    assign shutter_reset_pulse     = rs_adv;
    assign signal_sample_hold      = st_ff.ssh;
    assign row_reset_pulse         = st_ff.row_rst;
    assign row_reset_addr          = st_ff.rst_addr;
    assign reset_level_sample_hold = st_ff.rsh;
    assign crossbar_swapped        = st_ff.xbar;
    assign amp_operate             = st_ff.cfg[CFG_AMP_LSB +: 4];
    assign pixel_out0              = st_ff.out[0];
    assign pixel_out1              = st_ff.out[1];
    assign pixel_out2              = st_ff.out[2];
    assign pixel_out3              = st_ff.out[3];

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    xbar_toggle_a: assert property (
        xclk_rise && !crossbar_sync && st_ff.cfg[CFG_XB_AUTO] |=> st_ff.xbar != $past(st_ff.xbar))
        else $error("Crossbar did not toggle on its row clock.");
    xbar_sync_a: assert property (
        xclk_rise && crossbar_sync |=> st_ff.xbar == $past(st_ff.cfg[CFG_XB_INIT]))
        else $error("Crossbar sync did not load the initial state.");
    xbar_hold_a: assert property (
        !st_ff.cfg[CFG_XB_AUTO] && !(xclk_rise && crossbar_sync) |=> $stable(st_ff.xbar))
        else $error("Manual crossbar state changed without sync.");
    seq_order_a: assert property (
        $rose(signal_sample_hold) |=> row_reset_pulse ##1 reset_level_sample_hold)
        else $error("Double sampling steps out of order.");
    reset_addr_a: assert property (
        signal_sample_hold |-> row_reset_addr == $past(read_row))
        else $error("Second reset aimed at a row other than the one read.");
    cfg_commit_a: assert property (
        !$stable(st_ff.cfg) |-> $past(load_rise || cfg_wr))
        else $error("Configuration changed without a full word commit.");
    amp_standby_a: assert property (
        pixel_out1 != '0 |-> $past(st_ff.cfg[CFG_AMP_LSB + 1]))
        else $error("Standby output amplifier drove data.");
    route_green_a: assert property (
        st_ff.xbar && st_ff.cfg[CFG_AMP_LSB] |=> pixel_out0 == $past(st_ff.diff[1]))
        else $error("Swapped crossbar did not route column 1 to output 0.");
    bad_read_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > REG_COLUMN
        |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR)
        else $error("Unmapped read was not refused.");

endmodule // rpx_top
`default_nettype wire

// [verif/rpx_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module rpx_ctrl_model (
    input  wire logic aclk,
    output logic      readout_pointer_clock,
    output logic      readout_pointer_sync,
    output logic      reset_pointer_clock,
    output logic      reset_pointer_sync,
    output logic      column_clock,
    output logic      column_sync,
    output logic      crossbar_clock,
    output logic      crossbar_sync
);
    logic [2:0] clk_v = 3'h0;
    logic [2:0] syn_v = 3'h0;
    // The crossbar pins mirror the readout pointer pins.
    assign {column_clock, reset_pointer_clock, readout_pointer_clock} = clk_v;
    assign {column_sync, reset_pointer_sync, readout_pointer_sync} = syn_v;
    assign crossbar_clock = clk_v[0];
    assign crossbar_sync = syn_v[0];
    // Lead or coincidence of the two pointers is the caller's choice.
    task automatic pulse(input logic [2:0] m, input logic s);
        @(posedge aclk);
        clk_v <= m;
        syn_v <= s ? m : 3'h0;
        repeat (3) @(posedge aclk);
        clk_v <= 3'h0;
        syn_v <= 3'h0;
        repeat (3) @(posedge aclk);
    endtask
endmodule // rpx_ctrl_model
`default_nettype wire

// [verif/row_pointer_and_output_crossbar_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module row_pointer_and_output_crossbar_tb;
    import rpx_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic cfg_sclk, cfg_sdata, cfg_load, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, crossbar_swapped, readout_pointer_clock;
    logic readout_pointer_sync, reset_pointer_clock, reset_pointer_sync, column_clock;
    logic column_sync, crossbar_clock, crossbar_sync;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [PIX_W-1:0]  pix, pixel_out0, pixel_out1;
    logic [PTR_W-1:0]  read_row, reset_row;
    logic [3:0]        amp_operate;
    int                miscompares, num_checks;
    ////////////////////////////////////////
    rpx_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cfg_sclk, .cfg_sdata, .cfg_load, .readout_pointer_clock,
        .readout_pointer_sync, .reset_pointer_clock, .reset_pointer_sync, .column_clock,
        .column_sync, .crossbar_clock, .crossbar_sync, .pixel_level0(pix), .pixel_level1(pix),
        .pixel_level2(pix), .pixel_level3(pix), .read_row, .reset_row, .column(),
        .shutter_reset_pulse(), .signal_sample_hold(), .row_reset_pulse(), .row_reset_addr(),
        .reset_level_sample_hold(), .crossbar_swapped, .amp_operate, .pixel_out0, .pixel_out1,
        .pixel_out2(), .pixel_out3());
    rpx_ctrl_model i_ctl (.aclk, .readout_pointer_clock, .readout_pointer_sync,
        .reset_pointer_clock, .reset_pointer_sync, .column_clock, .column_sync,
        .crossbar_clock, .crossbar_sync);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 50) begin
            miscompares++;
            $display("[FAIL] %0t bus timeout", $time);
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        tmo(n);
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        tmo(n);
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    // Bits go in MSB first; the word only counts once the load pin rises.
    task automatic ser(input logic [11:0] w);
        for (int i = 11; i >= 0; i--) begin
            @(posedge aclk);
            cfg_sdata <= w[i];
            cfg_sclk <= 1'b1;
            repeat (2) @(posedge aclk);
            cfg_sclk <= 1'b0;
        end
        repeat (2) @(posedge aclk);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {cfg_sclk, cfg_sdata, cfg_load, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        pix = 10'h155;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(32'(amp_operate), 32'hF);
        rd(REG_CONFIG, 32'h7C1, RESP_OKAY);
        rd(8'h14, 32'h0, RESP_SLVERR);
        wr(8'h14, 32'h0, RESP_SLVERR);
        wr(REG_CONFIG, 32'h7C9, RESP_OKAY);
        i_ctl.pulse(3'h1, 1'b1);
        chk(32'(read_row), 32'h0);
        chk(32'(crossbar_swapped), 32'h0);
        for (int k = 1; k <= 2; k++) begin
            i_ctl.pulse(3'h1, 1'b0);
            chk(32'(read_row), 32'(k));
            chk(32'(crossbar_swapped), 32'(k % 2));
        end
        repeat (3) i_ctl.pulse(3'h2, 1'b0);
        chk(32'(reset_row), 32'h3);
        chk(32'(read_row), 32'h2);
        i_ctl.pulse(3'h3, 1'b1);
        chk(32'(reset_row | read_row), 32'h0);
        wr(REG_CONFIG, 32'hBC9, RESP_OKAY);
        i_ctl.pulse(3'h1, 1'b1);
        chk(32'(crossbar_swapped), 32'h1);
        i_ctl.pulse(3'h1, 1'b0);
        chk(32'(crossbar_swapped), 32'h1);
        ser(12'h549);
        chk(32'(amp_operate), 32'hF);
        cfg_load <= 1'b1;
        repeat (2) @(posedge aclk);
        cfg_load <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(32'(amp_operate), 32'h5);
        rd(REG_CONFIG, 32'h549, RESP_OKAY);
        i_ctl.pulse(3'h4, 1'b0);
        rd(REG_COLUMN, 32'h4, RESP_OKAY);
        // The level rises between the two samples, so a gated output cannot pass by luck.
        fork
            i_ctl.pulse(3'h1, 1'b0);
            begin
                repeat (5) @(posedge aclk);
                pix <= 10'h3FF;
            end
        join
        repeat (4) @(posedge aclk);
        chk(32'(pixel_out1), 32'h0);
        chk(32'(pixel_out0), 32'h2AA);
        rd(REG_READ_ROW, 32'h2, RESP_OKAY);
        rd(REG_STATUS, 32'h4, RESP_OKAY);
        summarize();
    end
endmodule // row_pointer_and_output_crossbar_tb
`default_nettype wire
